// >>> verilog/dcsw_pkg.sv
package dcsw_pkg;
	// control word bit positions
	localparam int CW_RAMP_STOP = 0;
	localparam int CW_COAST_STOP = 1;
	localparam int CW_QUICK_STOP = 2;
	localparam int CW_ENABLE_OP = 3;
	localparam int CW_RFG_ENABLE = 4;
	localparam int CW_RFG_RUN = 5;
	localparam int CW_SETPOINT_EN = 6;
	localparam int CW_FAULT_ACK = 7;
	localparam int CW_FIELDBUS_CTRL = 10;
	localparam int CW_REVERSE = 11;
	localparam int CW_POT_UP = 13;
	localparam int CW_POT_DOWN = 14;
	// status word bit positions
	localparam int SW_READY_TO_ON = 0;
	localparam int SW_READY = 1;
	localparam int SW_OP_ENABLED = 2;
	localparam int SW_FAULT = 3;
	localparam int SW_NO_COAST = 4;
	localparam int SW_NO_QUICK = 5;
	localparam int SW_ON_INHIBIT = 6;
	localparam int SW_ALARM = 7;
	localparam int SW_SPEED_TOL = 8;
	localparam int SW_MASTER_REQ = 9;
	localparam int SW_SPEED_REACHED = 10;
	localparam int SW_TORQUE_OK = 11;
	localparam int SW_RESERVED = 12;
	localparam int SW_MOTOR_TEMP_N = 13;
	localparam int SW_CLOCKWISE = 14;
	localparam int SW_INV_TEMP_N = 15;
	// reset values and the fixed reserved status bit value
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic SW_RESERVED_VALUE = 1'b0;
	localparam logic [15:0] SETPOINT_RESET = 16'h0000;

	// drive sequencer states
	typedef enum logic [4:0] {
		ST_INIT = 5'h01,
		ST_INHIBIT = 5'h02,
		ST_READY_ON = 5'h04,
		ST_READY = 5'h08,
		ST_RUN = 5'h10
	} dcsw_state_type;

	// ramp generator mode
	typedef enum logic [1:0] {
		RM_TRACK = 2'h0,
		RM_ZERO = 2'h1,
		RM_HOLD = 2'h2
	} dcsw_ramp_mode_type;

	// decoded commands
	typedef struct packed {
		logic ramp_stop;
		logic coast_stop;
		logic quick_stop;
		logic enable_op;
		logic setpoint_en;
		logic reverse;
		logic pot_up;
		logic pot_down;
		dcsw_ramp_mode_type ramp_mode;
	} dcsw_cmd_type;

	// monitored drive conditions
	typedef struct packed {
		logic fault;
		logic alarm;
		logic speed_tol;
		logic master_req;
		logic speed_reached;
		logic torque_ok;
		logic motor_overtemp;
		logic inverter_overload;
		logic speed_negative;
	} dcsw_cond_type;
endpackage : dcsw_pkg

// >>> verilog/dcsw_ctrl_decode.sv
`timescale 1ns/1ps
`default_nettype none
module dcsw_ctrl_decode (
	// word in
	input wire logic [15:0] word,
	// decoded
	output dcsw_pkg::dcsw_cmd_type cmd
);
	// control bits are active low for the stops
	wire logic rfg_zero = !word[dcsw_pkg::CW_RFG_ENABLE]; // [RQ6]
	wire logic rfg_hold = !word[dcsw_pkg::CW_RFG_RUN]; // [RQ6]
	// zero beats hold: a disabled generator cannot keep its value
	wire dcsw_pkg::dcsw_ramp_mode_type mode = rfg_zero ? dcsw_pkg::RM_ZERO :
		(rfg_hold ? dcsw_pkg::RM_HOLD : dcsw_pkg::RM_TRACK);

	assign cmd.ramp_stop = !word[dcsw_pkg::CW_RAMP_STOP]; // [RQ1]
	assign cmd.coast_stop = !word[dcsw_pkg::CW_COAST_STOP]; // [RQ3]
	assign cmd.quick_stop = !word[dcsw_pkg::CW_QUICK_STOP]; // [RQ4]
	assign cmd.enable_op = word[dcsw_pkg::CW_ENABLE_OP]; // [RQ5]
	assign cmd.setpoint_en = word[dcsw_pkg::CW_SETPOINT_EN]; // [RQ7]
	assign cmd.reverse = word[dcsw_pkg::CW_REVERSE]; // [RQ10]
	assign cmd.pot_up = word[dcsw_pkg::CW_POT_UP]; // [RQ11]
	assign cmd.pot_down = word[dcsw_pkg::CW_POT_DOWN]; // [RQ11]
	assign cmd.ramp_mode = mode;
endmodule : dcsw_ctrl_decode
`default_nettype wire

// >>> verilog/dcsw_status_pack.sv
`timescale 1ns/1ps
`default_nettype none
module dcsw_status_pack (
	// sequencer view
	input wire dcsw_pkg::dcsw_state_type state,
	input wire logic coast_active,
	input wire logic quick_active,
	input wire dcsw_pkg::dcsw_cond_type cond,
	// word out
	output logic [15:0] word
);
	always_comb begin
		word = 16'h0000;
		word[dcsw_pkg::SW_READY_TO_ON] = (state == dcsw_pkg::ST_READY_ON); // [RQ12]
		word[dcsw_pkg::SW_READY] = (state == dcsw_pkg::ST_READY) ||
			(state == dcsw_pkg::ST_RUN); // [RQ13]
		word[dcsw_pkg::SW_OP_ENABLED] = (state == dcsw_pkg::ST_RUN); // [RQ14]
		word[dcsw_pkg::SW_FAULT] = cond.fault; // [RQ15]
		word[dcsw_pkg::SW_NO_COAST] = !coast_active; // [RQ16]
		word[dcsw_pkg::SW_NO_QUICK] = !quick_active; // [RQ16]
		word[dcsw_pkg::SW_ON_INHIBIT] = (state == dcsw_pkg::ST_INHIBIT); // [RQ17]
		word[dcsw_pkg::SW_ALARM] = cond.alarm; // [RQ18]
		word[dcsw_pkg::SW_SPEED_TOL] = cond.speed_tol; // [RQ19]
		word[dcsw_pkg::SW_MASTER_REQ] = cond.master_req; // [RQ20]
		word[dcsw_pkg::SW_SPEED_REACHED] = cond.speed_reached; // [RQ19]
		word[dcsw_pkg::SW_TORQUE_OK] = cond.torque_ok; // [RQ19]
		word[dcsw_pkg::SW_RESERVED] = dcsw_pkg::SW_RESERVED_VALUE; // [RQ23]
		word[dcsw_pkg::SW_MOTOR_TEMP_N] = !cond.motor_overtemp; // [RQ21]
		word[dcsw_pkg::SW_CLOCKWISE] = !cond.speed_negative; // [RQ22]
		word[dcsw_pkg::SW_INV_TEMP_N] = !cond.inverter_overload; // [RQ21]
	end
endmodule : dcsw_status_pack
`default_nettype wire

// >>> verilog/dcsw_top.sv
// Summary of operation
// [RQ1] control bit 0 low: ramp down with normal time, drop drive at standstill.
// [RQ2] bit 0 rising: go ready; energize motor too if bit 3 set.
// [RQ3] control bit 1 low: drop drive at once, motor coasts.
// [RQ4] control bit 2 low: brake to standstill with quick-stop ramp time.
// [RQ5] control bit 3 low cancels pulses; high lets pulses be enabled.
// [RQ6] bit 4 low forces ramp output zero; bit 5 low freezes it.
// [RQ7] bit 6 low brakes with ramp-down time; high accelerates with ramp-up.
// [RQ8] bit 7 rising acknowledges faults; with on still set, go switch-on inhibited.
// [RQ9] bit 10 low ignores fieldbus process data; high accepts it.
// [RQ10] bit 11 set inverts the speed setpoint sign.
// [RQ11] bit 13 raises, bit 14 lowers the stored potentiometer setpoint.
// [RQ12] status bit 0: initialized, pulses locked, ready to switch on.
// [RQ13] status bit 1: switch-on given and no fault; waits for enable.
// [RQ14] status bit 2: operation enabled, motor follows setpoint.
// [RQ15] status bit 3: fault present; clears after acknowledge via bit 7.
// [RQ16] status bit 4: no coast stop; bit 5: no quick stop.
// [RQ17] status bit 6: switch-on inhibited; master must toggle switch-on.
// [RQ18] status bit 7: alarm present, motor stays on, no acknowledge.
// [RQ19] status bits 8, 10, 11: deviation ok, speed reached, torque below limit.
// [RQ20] status bit 9: requests master to take over control.
// [RQ21] status bits 13 and 15 low: motor overtemp, inverter overload.
// [RQ22] status bit 14: high for positive speed, low for negative.
// [RQ23] control bits 8, 9, 12, 15 ignored; status bit 12 fixed.
// [RQ24] levels act continuously; bits 0 and 7 edges against previous word.
`timescale 1ns/1ps
`default_nettype none
module dcsw_top #(
	parameter int WORD_W = 16,
	parameter int POT_STEP = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fieldbus process data
	input wire logic [WORD_W-1:0] ctrl_word,
	input wire logic ctrl_valid,
	input wire logic [WORD_W-1:0] speed_setpoint,
	// drive conditions
	input wire logic init_done,
	input wire logic fault_in,
	input wire logic alarm_in,
	input wire logic speed_tol_in,
	input wire logic master_req_in,
	input wire logic speed_reached_in,
	input wire logic torque_ok_in,
	input wire logic motor_overtemp_in,
	input wire logic inverter_overload_in,
	input wire logic speed_negative_in,
	input wire logic standstill_in,
	// ramp generator and power stage commands
	output logic pulse_enable,
	output logic ramp_down_active,
	output logic quick_stop_active,
	output logic ramp_up_active,
	output dcsw_pkg::dcsw_ramp_mode_type ramp_mode,
	output logic [WORD_W-1:0] setpoint_out,
	output logic [WORD_W-1:0] pot_setpoint,
	// status back to master
	output logic [15:0] drive_status_word,
	output logic [15:0] drive_control_word
);
	dcsw_pkg::dcsw_state_type state_reg, state_next;
	logic [15:0] ctrl_reg;
	logic [15:0] prev_reg;
	logic fault_reg;
	logic [WORD_W-1:0] pot_reg;
	logic [WORD_W-1:0] sp_reg;
	logic pulse_reg, rdown_reg, qstop_reg, rup_reg;
	dcsw_pkg::dcsw_ramp_mode_type mode_reg;
	logic [15:0] status_reg;

	dcsw_pkg::dcsw_cmd_type cmd;
	dcsw_pkg::dcsw_cond_type cond;
	wire logic [15:0] status_next;

	// only words with bit 10 set are taken as control data
	wire logic word_taken = ctrl_valid && ctrl_word[dcsw_pkg::CW_FIELDBUS_CTRL]; // [RQ9]
	// edges compare the new word with the previously taken one
	wire logic on_edge = word_taken && ctrl_word[dcsw_pkg::CW_RAMP_STOP] &&
		!prev_reg[dcsw_pkg::CW_RAMP_STOP]; // [RQ24] [RQ2]
	wire logic ack_edge = word_taken && ctrl_word[dcsw_pkg::CW_FAULT_ACK] &&
		!prev_reg[dcsw_pkg::CW_FAULT_ACK]; // [RQ24] [RQ8]
	// word as it stands after this cycle, so an edge sees its own enable bits
	wire logic [15:0] cur_word = word_taken ? ctrl_word : ctrl_reg;
	wire logic run_ok = !cmd.coast_stop && !cmd.quick_stop; // [RQ3] [RQ4]

	dcsw_ctrl_decode u_decode (
		.word(cur_word),
		.cmd(cmd)
	);

	assign cond.fault = fault_reg;
	assign cond.alarm = alarm_in;
	assign cond.speed_tol = speed_tol_in;
	assign cond.master_req = master_req_in;
	assign cond.speed_reached = speed_reached_in;
	assign cond.torque_ok = torque_ok_in;
	assign cond.motor_overtemp = motor_overtemp_in;
	assign cond.inverter_overload = inverter_overload_in;
	assign cond.speed_negative = speed_negative_in;

	dcsw_status_pack u_status (
		.state(state_next),
		.coast_active(cmd.coast_stop),
		.quick_active(cmd.quick_stop),
		.cond(cond),
		.word(status_next)
	);

	// pot arithmetic saturates at both ends
	function automatic logic [WORD_W-1:0] pot_step(input logic [WORD_W-1:0] v,
		input logic up, input logic dn);
		logic [WORD_W:0] s;
		s = {1'b0, v};
		pot_step = v;
		if (up && !dn) begin
			s = {1'b0, v} + (WORD_W+1)'(POT_STEP);
			pot_step = s[WORD_W] ? '1 : s[WORD_W-1:0];
		end else if (dn && !up) begin
			pot_step = (v < WORD_W'(POT_STEP)) ? '0 : v - WORD_W'(POT_STEP);
		end
	endfunction : pot_step

	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dcsw_pkg::ST_INIT: begin
				if (init_done)
					state_next = dcsw_pkg::ST_INHIBIT;
			end
			dcsw_pkg::ST_INHIBIT: begin
				// leave only after switch-on is taken away
				if (cmd.ramp_stop && run_ok)
					state_next = dcsw_pkg::ST_READY_ON; // [RQ17]
			end
			dcsw_pkg::ST_READY_ON: begin
				if (on_edge && run_ok && !fault_reg)
					state_next = cmd.enable_op ? dcsw_pkg::ST_RUN : dcsw_pkg::ST_READY; // [RQ2]
			end
			dcsw_pkg::ST_READY: begin
				if (cmd.enable_op)
					state_next = dcsw_pkg::ST_RUN; // [RQ13]
			end
			dcsw_pkg::ST_RUN: begin
				if (!cmd.enable_op)
					state_next = dcsw_pkg::ST_READY; // [RQ5]
			end
			default: state_next = dcsw_pkg::ST_INIT;
		endcase
		// coast stop overrides every state except ST_INIT; ramp and quick stop only ST_RUN or ST_READY at standstill
		if (state_reg != dcsw_pkg::ST_INIT) begin
			if (cmd.coast_stop)
				state_next = dcsw_pkg::ST_INHIBIT; // [RQ3]
			else if (fault_reg && !ack_edge)
				state_next = dcsw_pkg::ST_INHIBIT;
			else if (ack_edge && !cmd.ramp_stop)
				state_next = dcsw_pkg::ST_INHIBIT; // [RQ8]
			else if ((cmd.quick_stop || cmd.ramp_stop) && standstill_in &&
				(state_reg == dcsw_pkg::ST_RUN || state_reg == dcsw_pkg::ST_READY))
				state_next = cmd.quick_stop ? dcsw_pkg::ST_INHIBIT :
					dcsw_pkg::ST_READY_ON; // [RQ1] [RQ4]
		end
	end

	wire logic running = (state_next == dcsw_pkg::ST_RUN);
	// braking keeps pulses on until standstill
	wire logic braking = (state_reg == dcsw_pkg::ST_RUN) && !cmd.coast_stop &&
		cmd.enable_op && (cmd.ramp_stop || cmd.quick_stop) && !standstill_in;
	wire logic [WORD_W-1:0] signed_sp = cmd.reverse ? WORD_W'(-speed_setpoint) :
		speed_setpoint; // [RQ10]

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= dcsw_pkg::ST_INIT;
			ctrl_reg <= dcsw_pkg::CTRL_RESET;
			prev_reg <= dcsw_pkg::CTRL_RESET;
		end else begin
			state_reg <= state_next;
			if (word_taken) begin
				ctrl_reg <= ctrl_word; // [RQ23]
				prev_reg <= ctrl_word; // [RQ24]
			end
		end
	end

	// fault is sticky; a new fault beats the acknowledge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			fault_reg <= 1'b0;
		else
			fault_reg <= fault_in || (fault_reg && !ack_edge); // [RQ15]
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pot_reg <= dcsw_pkg::SETPOINT_RESET;
			sp_reg <= dcsw_pkg::SETPOINT_RESET;
		end else begin
			pot_reg <= pot_step(pot_reg, cmd.pot_up, cmd.pot_down); // [RQ11]
			if (word_taken)
				sp_reg <= signed_sp; // [RQ9] [RQ10]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_reg <= 1'b0;
			rdown_reg <= 1'b0;
			qstop_reg <= 1'b0;
			rup_reg <= 1'b0;
			mode_reg <= dcsw_pkg::RM_ZERO;
			status_reg <= 16'h0000;
		end else begin
			pulse_reg <= running || braking; // [RQ5] [RQ1]
			qstop_reg <= (running || braking) && cmd.quick_stop; // [RQ4]
			rdown_reg <= (running || braking) && !cmd.quick_stop &&
				(cmd.ramp_stop || !cmd.setpoint_en); // [RQ1] [RQ7]
			rup_reg <= running && !cmd.ramp_stop && !cmd.quick_stop &&
				cmd.setpoint_en; // [RQ7]
			mode_reg <= cmd.ramp_mode; // [RQ6]
			status_reg <= status_next; // [RQ12] [RQ16]
		end
	end

	assign pulse_enable = pulse_reg;
	assign ramp_down_active = rdown_reg;
	assign quick_stop_active = qstop_reg;
	assign ramp_up_active = rup_reg;
	assign ramp_mode = mode_reg;
	assign setpoint_out = sp_reg;
	assign pot_setpoint = pot_reg;
	assign drive_status_word = status_reg;
	assign drive_control_word = ctrl_reg;
endmodule : dcsw_top
`default_nettype wire

// >>> testbench/dcsw_master.sv
`timescale 1ns/1ps
`default_nettype none
module dcsw_master (
	// clock
	input wire logic clk,
	// process data
	output logic [15:0] ctrl_word,
	output logic ctrl_valid,
	output logic [15:0] speed_setpoint
);
	initial begin
		ctrl_word = 16'h0000;
		ctrl_valid = 1'b0;
		speed_setpoint = 16'h0000;
	end
	// released lines show the inverse so a stale word is never taken for a held one
	task send(input logic [15:0] w, input logic [15:0] sp);
		@(negedge clk);
		ctrl_word = w;
		speed_setpoint = sp;
		ctrl_valid = 1'b1;
		@(negedge clk);
		ctrl_valid = 1'b0;
		ctrl_word = ~w;
		speed_setpoint = ~sp;
	endtask : send
endmodule : dcsw_master
`default_nettype wire

// >>> testbench/dcsw_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dcsw_top_chk #(
	parameter int WORD_W = 16,
	parameter int POT_STEP = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fieldbus
	input wire logic [WORD_W-1:0] ctrl_word,
	input wire logic ctrl_valid,
	input wire logic [WORD_W-1:0] speed_setpoint,
	// conditions
	input wire logic alarm_in,
	input wire logic speed_tol_in,
	input wire logic master_req_in,
	input wire logic speed_reached_in,
	input wire logic torque_ok_in,
	input wire logic motor_overtemp_in,
	input wire logic inverter_overload_in,
	input wire logic speed_negative_in,
	// outputs
	input wire logic pulse_enable,
	input wire dcsw_pkg::dcsw_ramp_mode_type ramp_mode,
	input wire logic [WORD_W-1:0] setpoint_out,
	input wire logic [WORD_W-1:0] pot_setpoint,
	input wire logic [15:0] drive_status_word,
	input wire logic [15:0] drive_control_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic take = ctrl_valid && ctrl_word[10];
	wire logic [7:0] cnd = {inverter_overload_in, speed_negative_in, motor_overtemp_in,
		torque_ok_in, speed_reached_in, master_req_in, speed_tol_in, alarm_in};
	a_word_taken: assert property (
		take |=> drive_control_word == $past(ctrl_word)) else $error("word not stored");
	a_word_ignored: assert property (
		ctrl_valid && !ctrl_word[10] |=> $stable(drive_control_word)) else $error("word not ignored");
	a_setpoint_sign: assert property (
		take |=> setpoint_out == ($past(ctrl_word[11]) ? WORD_W'(-$past(speed_setpoint)) :
		$past(speed_setpoint))) else $error("setpoint sign wrong");
	a_ramp_mode_sel: assert property (
		ramp_mode == (!drive_control_word[4] ? dcsw_pkg::RM_ZERO : !drive_control_word[5] ?
		dcsw_pkg::RM_HOLD : dcsw_pkg::RM_TRACK)) else $error("ramp mode wrong");
	a_pulse_cut: assert property (
		!(drive_control_word[1] && drive_control_word[3]) |-> !pulse_enable) else $error("pulses on");
	a_no_coast_flag: assert property (
		drive_status_word[4] == drive_control_word[1]) else $error("coast flag wrong");
	a_cond_copy: assert property (
		!$past(sys_rst) |-> drive_status_word[11:7] == $past(cnd[4:0]) &&
		drive_status_word[15:13] == ~$past(cnd[7:5])) else $error("condition bits wrong");
	a_reserved_zero: assert property (
		drive_status_word[12] == dcsw_pkg::SW_RESERVED_VALUE) else $error("reserved bit wrong");
	a_pot_step: assert property (
		drive_control_word[14:13] == 2'b01 && !take && pot_setpoint < 16'h7000
		|=> pot_setpoint == $past(pot_setpoint) + POT_STEP) else $error("pot step wrong");
endmodule : dcsw_top_chk
bind dcsw_top dcsw_top_chk #(.WORD_W(WORD_W), .POT_STEP(POT_STEP)) chk_u (.clk(clk),
	.sys_rst(sys_rst), .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid),
	.speed_setpoint(speed_setpoint), .alarm_in(alarm_in), .speed_tol_in(speed_tol_in),
	.master_req_in(master_req_in), .speed_reached_in(speed_reached_in),
	.torque_ok_in(torque_ok_in), .motor_overtemp_in(motor_overtemp_in),
	.inverter_overload_in(inverter_overload_in), .speed_negative_in(speed_negative_in),
	.pulse_enable(pulse_enable), .ramp_mode(ramp_mode), .setpoint_out(setpoint_out),
	.pot_setpoint(pot_setpoint), .drive_status_word(drive_status_word),
	.drive_control_word(drive_control_word));
`default_nettype wire

// >>> testbench/dcsw_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dcsw_top_bench;
	localparam int PSTEP = 2;
	logic clk;
	logic sys_rst;
	logic init_done;
	logic fault_in;
	logic stand;
	logic chk_on;
	logic [7:0] cnd = 8'h00;
	logic [15:0] w, sp, ew, es, p;
	int n_errors;
	int n_checks;
	int cyc;
	integer seed;
	wire logic [15:0] cw, spt, st, dcw, so, pot;
	wire logic cv, pe, rd, qs, ru;
	wire dcsw_pkg::dcsw_ramp_mode_type rm;
	dcsw_master master_u (.clk(clk), .ctrl_word(cw), .ctrl_valid(cv), .speed_setpoint(spt));
	dcsw_top #(.POT_STEP(PSTEP)) dut_u (.clk(clk), .sys_rst(sys_rst), .ctrl_word(cw),
		.ctrl_valid(cv), .speed_setpoint(spt), .init_done(init_done), .fault_in(fault_in),
		.alarm_in(cnd[0]), .speed_tol_in(cnd[1]), .master_req_in(cnd[2]),
		.speed_reached_in(cnd[3]), .torque_ok_in(cnd[4]), .motor_overtemp_in(cnd[5]),
		.speed_negative_in(cnd[6]), .inverter_overload_in(cnd[7]), .standstill_in(stand),
		.pulse_enable(pe), .ramp_down_active(rd), .quick_stop_active(qs), .ramp_up_active(ru),
		.ramp_mode(rm), .setpoint_out(so), .pot_setpoint(pot), .drive_status_word(st),
		.drive_control_word(dcw));
	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task tx(input logic [15:0] v);
		master_u.send(v, 16'h0000);
	endtask : tx
	task test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	function automatic logic [15:0] exp_io(input logic [7:0] c);
		return {~c[7:5], dcsw_pkg::SW_RESERVED_VALUE, c[4:0], 7'h00};
	endfunction : exp_io
	function automatic logic [1:0] exp_rm(input logic [15:0] v);
		return !v[4] ? 2'h1 : !v[5] ? 2'h2 : 2'h0;
	endfunction : exp_rm
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk) begin
		if (chk_on) begin
			chk(st & 16'hff80, exp_io(cnd), "condition bits");
		end
		cnd <= 8'($random(seed));
	end
	// run is well under a thousand cycles; the ceiling only catches a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		seed = 32'h75b4;
		{sys_rst, init_done, fault_in, stand, chk_on} = 5'b10000;
		{n_errors, n_checks, cyc} = '0;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		{chk_on, init_done} = 2'b11;
		repeat (2) @(negedge clk);
		chk(st & 16'h0040, 16'h0040, "inhibit at start");
		tx(16'h0406);
		chk(st & 16'h0047, 16'h0001, "ready to switch on");
		tx(16'h047f);
		chk(st & 16'h0046, 16'h0006, "running");
		@(negedge clk);
		chk({14'h0, pe, ru}, 16'h3, "pulses and ramp up");
		tx(16'h007e);
		chk({dcw[15:1], pe}, 16'h047f, "word ignored");
		tx(16'h047b);
		@(negedge clk);
		chk({st[15:1], qs} & 16'h0031, 16'h0011, "quick stop");
		stand = 1'b1;
		repeat (3) @(negedge clk);
		chk(st & 16'h0044, 16'h0040, "quick stop ends inhibited");
		stand = 1'b0;
		tx(16'h047e);
		tx(16'h047f);
		tx(16'h047d);
		@(negedge clk);
		chk({st[15:1], pe} & 16'h0015, 16'h0000, "coast stop");
		tx(16'h047e);
		tx(16'h047f);
		tx(16'h047e);
		@(negedge clk);
		chk(16'(rd), 16'h1, "ramp stop brakes");
		stand = 1'b1;
		repeat (3) @(negedge clk);
		chk({st[15:1], pe} & 16'h0047, 16'h0000, "ramp stop at standstill");
		stand = 1'b0;
		tx(16'h047f);
		tx(16'h043f);
		@(negedge clk);
		chk({14'h0, rd, ru}, 16'h2, "setpoint inhibit");
		tx(16'h0437);
		@(negedge clk);
		chk(16'(pe), 16'h0, "operation inhibit");
		for (int k = 0; k < 2; k++) begin
			@(negedge clk) fault_in = 1'b1;
			@(negedge clk) fault_in = 1'b0;
			// status shows the latched fault one edge after it is taken
			@(negedge clk);
			chk(st & 16'h0048, 16'h0048, "fault held");
			tx(k ? 16'h0477 : 16'h0437);
			tx(k ? 16'h04f7 : 16'h04f6);
			@(negedge clk);
			chk(st & 16'h0048, k ? 16'h0040 : 16'h0000, "fault acknowledged");
		end
		tx(16'h0476);
		tx(16'h047f);
		chk(16'(pe), 16'h1, "on after toggle");
		tx(16'h247f);
		p = pot;
		repeat (20) @(negedge clk);
		chk(pot, p + 16'(20 * PSTEP), "pot up");
		tx(16'h447f);
		p = pot;
		repeat (10) @(negedge clk);
		chk(pot, p - 16'(10 * PSTEP), "pot down");
		{ew, es} = {16'h447f, 16'h0000};
		for (int i = 0; i < 60; i++) begin
			w = 16'($random(seed));
			sp = 16'($random(seed));
			master_u.send(w, sp);
			if (w[10]) begin
				ew = w;
				es = w[11] ? -sp : sp;
			end
			chk(dcw, ew, "stored word");
			chk(so, es, "setpoint sign");
			chk(16'(rm), 16'(exp_rm(ew)), "ramp mode");
			repeat ($unsigned($random(seed)) % 3) @(negedge clk);
		end
		test_done();
	end
endmodule : dcsw_top_bench
`default_nettype wire
